// ===== acr_pkg.sv
// Operation
// - an instruction is a two-character command code followed by its parameters and is decoded in that form.
// - a semicolon separates instructions on one line and each is handled on its own.
// - the answer to an instruction goes out only on the port the instruction came in on.
// - an accepted instruction is answered with a colon and a refused one with a question mark.
// - a query that returns data sends the data, then carriage return, line feed and the colon.
// - the echo-enable command with argument 1 makes the block echo every received character.
// - while a program runs, message output and command errors leave as unsolicited output.
// - unsolicited output goes to the named port, else the default port, else the main serial port.
// - on the network, unsolicited output uses a handle other than the main command handle.
// - unsolicited-format argument 1 sets the top bit of each unsolicited character, argument 2 clears that mode.
`default_nettype none
package acr_pkg;
  // ==========================================================================
  // characters
  localparam logic [7:0] CHAR_CR    = 8'h0D;
  localparam logic [7:0] CHAR_LF    = 8'h0A;
  localparam logic [7:0] CHAR_SEMI  = 8'h3B;
  localparam logic [7:0] CHAR_COLON = 8'h3A;
  localparam logic [7:0] CHAR_QMARK = 8'h3F;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_ZERO  = 8'h30;
  localparam logic [7:0] CHAR_NINE  = 8'h39;
  localparam logic [7:0] CHAR_HEX_A = 8'h41;
  localparam logic [7:0] MARK_BIT   = 8'h80;
  // ==========================================================================
  // command codes, first character in the upper byte
  localparam logic [15:0] CODE_ECHO_ENABLE     = 16'h454F;
  localparam logic [15:0] CODE_UNSOL_FORMAT    = 16'h4357;
  localparam logic [15:0] CODE_DEFAULT_PORT    = 16'h4346;
  localparam logic [15:0] CODE_POSITION_QUERY  = 16'h5450;
  // ==========================================================================
  // arguments, ports, reset values
  localparam logic [7:0] ARG_ECHO_ON   = 8'h01;
  localparam logic [7:0] ARG_MARK_ON   = 8'h01;
  localparam logic [7:0] ARG_MARK_OFF  = 8'h02;
  localparam logic       PORT_SERIAL   = 1'b0;
  localparam logic       PORT_NET      = 1'b1;
  localparam logic       RST_ECHO      = 1'b0;
  localparam logic       RST_MARK      = 1'b0;
  localparam logic       RST_DEF_PORT  = PORT_SERIAL;
  localparam int         QUERY_DIGITS  = 8;
  localparam int         POS_W         = 32;

  typedef struct packed {
    logic [7:0] data;
    logic       port;
    logic       unsol;
  } tx_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       has_port;
    logic       port;
  } msg_t;
endpackage : acr_pkg
`default_nettype wire

// ===== ascii_command_responder.sv
`timescale 1ns/10ps
`default_nettype none
module ascii_command_responder (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [1:0]            rx_valid,
  input  wire logic [15:0]           rx_data,
  output logic      [1:0]            rx_ready,
  output logic                       tx_valid,
  output acr_pkg::tx_t               tx,
  input  wire logic                  tx_ready,
  input  wire logic [31:0]           position,
  input  wire logic                  prog_running,
  input  wire logic                  msg_valid,
  input  wire acr_pkg::msg_t         msg,
  output logic                       msg_ready,
  input  wire logic                  prog_error,
  output logic                       echo_on,
  output logic                       mark_on,
  output logic                       default_port
);
  import acr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ECHO, ST_PROC, ST_DATA, ST_CR, ST_LF, ST_ACK, ST_UNSOL
  } state_t;

  // ==========================================================================
  // state
  state_t      state_q,  state_d;
  logic [7:0]  cur_q,    cur_d;
  logic        lport_q,  lport_d;
  logic        lact_q,   lact_d;
  logic [1:0]  cnt_q,    cnt_d;
  logic [15:0] code_q,   code_d;
  logic [7:0]  arg_q,    arg_d;
  logic        harg_q,   harg_d;
  logic        bad_q,    bad_d;
  logic [7:0]  ack_q,    ack_d;
  logic [31:0] pos_q,    pos_d;
  logic [3:0]  dig_q,    dig_d;
  logic        echo_q,   echo_d;
  logic        mark_q,   mark_d;
  logic        dport_q,  dport_d;
  logic        errp_q,   errp_d;
  logic        unerr_q,  unerr_d;

  logic        sel;
  logic        take;
  logic [7:0]  sel_ch;
  logic [3:0]  nib;
  logic [7:0]  hex_ch;
  logic [7:0]  un_ch;
  logic        ok;

  assign echo_on      = echo_q;
  assign mark_on      = mark_q;
  assign default_port = dport_q;

  // ==========================================================================
  // port selection, a line locks its port
  always_comb begin
    if (lact_q) begin
      sel = lport_q;
    end else begin
      sel = rx_valid[0] ? 1'b0 : 1'b1;
    end
    sel_ch   = sel ? rx_data[15:8] : rx_data[7:0];
    take     = (state_q == ST_IDLE) && rx_valid[sel];
    rx_ready = 2'b00;
    rx_ready[sel] = (state_q == ST_IDLE);
    nib      = pos_q[31:28];
    hex_ch   = (nib < 4'hA) ? CHAR_ZERO + {4'h0, nib} : CHAR_HEX_A + {4'h0, nib} - 8'h0A;
    un_ch    = (unerr_q ? CHAR_QMARK : msg.data) | (mark_q ? MARK_BIT : 8'h00);
  end

  // ==========================================================================
  // decode of a complete instruction
  always_comb begin
    ok = 1'b0;
    if ((cnt_q == 2'd2) && !bad_q) begin
      case (code_q)
        CODE_ECHO_ENABLE:    ok = harg_q && (arg_q <= ARG_ECHO_ON);
        CODE_UNSOL_FORMAT:   ok = harg_q && ((arg_q == ARG_MARK_ON) || (arg_q == ARG_MARK_OFF));
        CODE_DEFAULT_PORT:   ok = harg_q && (arg_q <= 8'h01);
        CODE_POSITION_QUERY: ok = !harg_q;
        default:             ok = 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // output mux
  always_comb begin
    tx_valid  = 1'b0;
    tx        = '{data: cur_q, port: lport_q, unsol: 1'b0};
    msg_ready = 1'b0;
    case (state_q)
      ST_ECHO: tx_valid = 1'b1;
      ST_DATA: begin
        tx_valid = 1'b1;
        tx.data  = hex_ch;
      end
      ST_CR: begin
        tx_valid = 1'b1;
        tx.data  = CHAR_CR;
      end
      ST_LF: begin
        tx_valid = 1'b1;
        tx.data  = CHAR_LF;
      end
      ST_ACK: begin
        tx_valid = 1'b1;
        tx.data  = ack_q;
      end
      ST_UNSOL: begin
        tx_valid  = 1'b1;
        tx.data   = un_ch;
        tx.port   = (!unerr_q && msg.has_port) ? msg.port : dport_q;
        tx.unsol  = 1'b1;
        msg_ready = !unerr_q && tx_ready;
      end
      default: tx_valid = 1'b0;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    state_d = state_q;
    cur_d   = cur_q;
    lport_d = lport_q;
    lact_d  = lact_q;
    cnt_d   = cnt_q;
    code_d  = code_q;
    arg_d   = arg_q;
    harg_d  = harg_q;
    bad_d   = bad_q;
    ack_d   = ack_q;
    pos_d   = pos_q;
    dig_d   = dig_q;
    echo_d  = echo_q;
    mark_d  = mark_q;
    dport_d = dport_q;
    unerr_d = unerr_q;
    errp_d  = errp_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          cur_d   = sel_ch;
          lport_d = sel;
          lact_d  = 1'b1;
          state_d = echo_q ? ST_ECHO : ST_PROC;
        end else if (prog_running && (errp_q || msg_valid)) begin
          unerr_d = errp_q;
          state_d = ST_UNSOL;
        end
      end
      ST_ECHO: begin
        if (tx_ready) begin
          state_d = ST_PROC;
        end
      end
      ST_PROC: begin
        state_d = ST_IDLE;
        if ((cur_q == CHAR_CR) || (cur_q == CHAR_SEMI)) begin
          if (cur_q == CHAR_CR) begin
            lact_d = 1'b0;
          end
          cnt_d  = 2'd0;
          harg_d = 1'b0;
          bad_d  = 1'b0;
          arg_d  = 8'h00;
          if ((cnt_q != 2'd0) || bad_q) begin
            ack_d = ok ? CHAR_COLON : CHAR_QMARK;
            if (ok && (code_q == CODE_POSITION_QUERY)) begin
              pos_d   = position;
              dig_d   = 4'd0;
              state_d = ST_DATA;
            end else begin
              state_d = ST_ACK;
            end
            if (ok && (code_q == CODE_ECHO_ENABLE)) begin
              echo_d = (arg_q == ARG_ECHO_ON);
            end
            if (ok && (code_q == CODE_UNSOL_FORMAT)) begin
              mark_d = (arg_q == ARG_MARK_ON);
            end
            if (ok && (code_q == CODE_DEFAULT_PORT)) begin
              dport_d = arg_q[0];
            end
          end
        end else if (cur_q != CHAR_SPACE) begin
          if (cnt_q != 2'd2) begin
            code_d = {code_q[7:0], cur_q};
            cnt_d  = cnt_q + 2'd1;
          end else if ((cur_q >= CHAR_ZERO) && (cur_q <= CHAR_NINE)) begin
            harg_d = 1'b1;
            arg_d  = 8'({arg_q, 3'b000} + {arg_q, 1'b0} + (cur_q - CHAR_ZERO));
            bad_d  = bad_q || (({4'h0, arg_q} * 12'h00A + {4'h0, cur_q - CHAR_ZERO}) > 12'h0FF);
          end else begin
            bad_d = 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (tx_ready) begin
          pos_d = {pos_q[27:0], 4'h0};
          dig_d = dig_q + 4'd1;
          if (dig_q == 4'(QUERY_DIGITS - 1)) begin
            state_d = ST_CR;
          end
        end
      end
      ST_CR: begin
        if (tx_ready) begin
          state_d = ST_LF;
        end
      end
      ST_LF: begin
        if (tx_ready) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (tx_ready) begin
          state_d = ST_IDLE;
        end
      end
      ST_UNSOL: begin
        if (tx_ready && (unerr_q || msg.last)) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // error event set wins over clear
    if (state_q == ST_UNSOL && unerr_q && tx_ready) begin
      errp_d = 1'b0;
    end
    if (prog_error) begin
      errp_d = 1'b1;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cur_q   <= 8'h00;
      lport_q <= PORT_SERIAL;
      lact_q  <= 1'b0;
      cnt_q   <= 2'd0;
      code_q  <= 16'h0000;
      arg_q   <= 8'h00;
      harg_q  <= 1'b0;
      bad_q   <= 1'b0;
      ack_q   <= CHAR_COLON;
      pos_q   <= 32'h0000_0000;
      dig_q   <= 4'h0;
      echo_q  <= RST_ECHO;
      mark_q  <= RST_MARK;
      dport_q <= RST_DEF_PORT;
      errp_q  <= 1'b0;
      unerr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q   <= cur_d;
      lport_q <= lport_d;
      lact_q  <= lact_d;
      cnt_q   <= cnt_d;
      code_q  <= code_d;
      arg_q   <= arg_d;
      harg_q  <= harg_d;
      bad_q   <= bad_d;
      ack_q   <= ack_d;
      pos_q   <= pos_d;
      dig_q   <= dig_d;
      echo_q  <= echo_d;
      mark_q  <= mark_d;
      dport_q <= dport_d;
      errp_q  <= errp_d;
      unerr_q <= unerr_d;
    end
  end
endmodule : ascii_command_responder
`default_nettype wire

// ===== acr_host.sv
`timescale 1ns/10ps
`default_nettype none
module acr_host (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         stall,
  input  wire logic         tx_valid,
  input  wire acr_pkg::tx_t tx,
  output var  logic         tx_ready
);
  import acr_pkg::*;
  // ==========================================
  // sink, one log takes answers and unsolicited output alike
  tx_t got [64];
  int  n_got;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      n_got    <= 0;
    end else begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got[n_got[5:0]] <= tx;
        n_got           <= n_got + 1;
      end
    end
  end
endmodule : acr_host
`default_nettype wire

// ===== ascii_command_responder_chk.sv
`timescale 1ns/10ps
`default_nettype none
module acr_chk (
  input wire logic          clk,
  input wire logic          nrst,
  input wire logic [1:0]    rx_valid,
  input wire logic [15:0]   rx_data,
  input wire logic [1:0]    rx_ready,
  input wire logic          tx_valid,
  input wire acr_pkg::tx_t  tx,
  input wire logic          tx_ready,
  input wire acr_pkg::msg_t msg,
  input wire logic          msg_valid,
  input wire logic          msg_ready,
  input wire logic          prog_running,
  input wire logic          echo_on,
  input wire logic          mark_on,
  input wire logic          default_port
);
  import acr_pkg::*;
  // ==========================================
  // port of the last taken char
  logic last_port_q;
  logic last_port_d;
  logic msg_dest;
  assign msg_dest = msg.has_port ? msg.port : default_port;
  always_comb begin
    last_port_d = last_port_q;
    if (|(rx_valid & rx_ready)) last_port_d = rx_valid[1] & rx_ready[1];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) last_port_q <= PORT_SERIAL;
    else last_port_q <= last_port_d;
  end
  // ==========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_stalled; tx_valid && !tx_ready; endsequence
  sequence s_lf_out; tx_valid && tx_ready && !tx.unsol && tx.data == CHAR_LF; endsequence
  sequence s_cr_out; tx_valid && tx_ready && !tx.unsol && tx.data == CHAR_CR; endsequence
  sequence s_echo_take; echo_on && rx_valid[0] && rx_ready[0]; endsequence
  sequence s_msg_take; msg_valid && msg_ready; endsequence
  a_tx_holds: assert property (s_stalled |=> tx_valid && $stable(tx))
    else $error("tx moved while stalled");
  a_rx_busy: assert property (tx_valid |-> rx_ready == 2'b00)
    else $error("char taken while answering");
  a_lf_colon: assert property (s_lf_out |=> tx_valid && tx.data == CHAR_COLON)
    else $error("no colon after line feed");
  a_cr_lf: assert property (s_cr_out ##1 tx_valid |-> tx.data == CHAR_LF)
    else $error("no line feed after return");
  a_echo_char: assert property (s_echo_take |=> tx_valid && tx.data == $past(rx_data[7:0]))
    else $error("echo wrong");
  a_answer_port: assert property (tx_valid && !tx.unsol |-> tx.port == last_port_q)
    else $error("answer on wrong port");
  a_unsol_prog: assert property ($rose(tx_valid && tx.unsol) |-> $past(prog_running))
    else $error("unsolicited without program");
  a_unsol_mark: assert property (tx_valid && tx.unsol |-> tx.data[7] == mark_on)
    else $error("top bit wrong");
  a_msg_route: assert property (s_msg_take |-> tx_valid && tx.unsol && tx.port == msg_dest)
    else $error("message port wrong");
endmodule : acr_chk
bind ascii_command_responder acr_chk u_chk (.clk(clk), .nrst(nrst), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready),
  .msg(msg), .msg_valid(msg_valid), .msg_ready(msg_ready), .prog_running(prog_running),
  .echo_on(echo_on), .mark_on(mark_on), .default_port(default_port));
`default_nettype wire

// ===== ascii_command_responder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ascii_command_responder_tb_top;
  import acr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, tx_valid, tx_ready, stall = 1'b0;
  logic [1:0] rx_valid = 2'b00, rx_ready;
  logic [15:0] rx_data = 16'h0000;
  logic [31:0] position = 32'h0000_0000;
  logic prog_running = 1'b0, msg_valid = 1'b0, prog_error = 1'b0;
  logic msg_ready, echo_on, mark_on, default_port;
  tx_t tx;
  msg_t msg = '0;
  int num_errors = 0, check_count = 0, cycles = 0, rd = 0;
  always #2.5 clk = ~clk;
  ascii_command_responder dut (.clk(clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx(tx), .tx_ready(tx_ready), .position(position),
    .prog_running(prog_running), .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready),
    .prog_error(prog_error), .echo_on(echo_on), .mark_on(mark_on), .default_port(default_port));
  acr_host host (.clk(clk), .nrst(nrst), .stall(stall), .tx_valid(tx_valid), .tx(tx),
    .tx_ready(tx_ready));
  // ==========================================
  // report and compare
  task automatic summarize();
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk_bit(logic g, logic e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_bit
  task automatic chk_tx(tx_t g, tx_t e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_tx
  // ==========================================
  // drivers, every command line closed by cr, messages ended by last
  task automatic send(string s, logic p);
    for (int i = 0; i <= s.len(); i++) begin
      rx_valid[p] <= 1'b1;
      rx_data[8*p +: 8] <= (i < s.len()) ? s[i] : CHAR_CR;
      @(posedge clk);
      while (!rx_ready[p]) @(posedge clk);
    end
    rx_valid[p] <= 1'b0;
    rx_data <= ~rx_data;
  endtask : send
  task automatic send_msg(string s, logic hp, logic pt);
    for (int i = 0; i < s.len(); i++) begin
      msg_valid <= 1'b1;
      msg <= '{s[i], i == s.len() - 1, hp, pt};
      @(posedge clk);
      while (!msg_ready) @(posedge clk);
    end
    msg_valid <= 1'b0;
    msg <= ~msg;
  endtask : send_msg
  task automatic expect_str(string s, logic p, logic u, logic m);
    int  k;
    tx_t e;
    k = 0;
    while (host.n_got - rd < s.len() && k < 400) begin
      @(posedge clk);
      k++;
    end
    for (int i = 0; i < s.len(); i++) begin
      e = '{s[i] | (m ? MARK_BIT : 8'h00), p, u};
      chk_tx(rd < host.n_got ? host.got[rd[5:0]] : '0, e);
      rd++;
    end
  endtask : expect_str
  // ==========================================
  // scenarios
  task automatic t_query();
    position <= 32'h1234_abcd;
    send("TP", PORT_SERIAL);
    expect_str("1234ABCD\015\012:", PORT_SERIAL, 1'b0, 1'b0);
  endtask : t_query
  task automatic t_echo();
    send("EO 1", PORT_SERIAL);
    expect_str(":", PORT_SERIAL, 1'b0, 1'b0);
    chk_bit(echo_on, 1'b1);
    send("CW1", PORT_SERIAL);
    expect_str("CW1\015:", PORT_SERIAL, 1'b0, 1'b0);
    chk_bit(mark_on, 1'b1);
    send("EO0", PORT_SERIAL);
    expect_str("EO0\015:", PORT_SERIAL, 1'b0, 1'b0);
    chk_bit(echo_on, 1'b0);
  endtask : t_echo
  task automatic t_refuse();
    send("CW3;EO256;TP1;E;CF 0", PORT_SERIAL);
    expect_str("????:", PORT_SERIAL, 1'b0, 1'b0);
    chk_bit(mark_on, 1'b1);
    chk_bit(echo_on, 1'b0);
    chk_bit(default_port, PORT_SERIAL);
  endtask : t_refuse
  task automatic t_concat();
    stall <= 1'b1;
    send("XY;CF1;;TP", PORT_NET);
    expect_str("?:1234ABCD\015\012:", PORT_NET, 1'b0, 1'b0);
    chk_bit(default_port, PORT_NET);
  endtask : t_concat
  task automatic t_unsol();
    prog_running <= 1'b1;
    send_msg("HI", 1'b0, 1'b0);
    expect_str("HI", PORT_NET, 1'b1, 1'b1);
    prog_error <= 1'b1;
    @(posedge clk);
    prog_error <= 1'b0;
    expect_str("?", PORT_NET, 1'b1, 1'b1);
    send("CW2", PORT_SERIAL);
    expect_str(":", PORT_SERIAL, 1'b0, 1'b0);
    send_msg("Z", 1'b1, PORT_SERIAL);
    expect_str("Z", PORT_SERIAL, 1'b1, 1'b0);
  endtask : t_unsol
  // ==========================================
  // main sequence and timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    chk_bit(echo_on, RST_ECHO);
    chk_bit(mark_on, RST_MARK);
    chk_bit(default_port, RST_DEF_PORT);
    nrst <= 1'b1;
    t_query();
    t_echo();
    t_refuse();
    t_concat();
    t_unsol();
    summarize();
  end
endmodule : ascii_command_responder_tb_top
`default_nettype wire
